// ---- rtl/posc_top.sv ----
// module: start-up levels, pin override register and shared host pins of the reclocker
`timescale 1ns/1ns

// Behaviour
// - override values act only with enable bit set
// - register-only functions default from pull resistors
// - bypass high routes input around reclocker
// - autobypass bypasses while pll lacks supported lock
// - rate mode high selects automatic rate detection
// - auto mode drives locked rate on rate pins
// - loop bandwidth control sets pll bandwidth level
// - low mute silences primary and secondary data
// - secondary output selects data high, clock low
// - deemphasis enable turns output deemphasis on
// - low interface select gives spi host pins
module posc_top (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // shared host pins
  input  wire logic       host_interface_select,
  input  wire logic       cs_eq3_pin,
  input  wire logic       sck_eq2_pin,
  input  wire logic       sdi_eq0_pin,
  input  wire logic       sdo_eq1_in,
  output logic            sdo_eq1_out,
  output logic            sdo_eq1_oe,
  // rate select pins
  input  wire logic [1:0] rate_select_in,
  output logic      [1:0] rate_select_out,
  output logic            rate_select_oe,
  // pll status
  input  wire logic       pll_locked,
  input  wire logic       pll_rate_supported,
  input  wire logic [1:0] pll_locked_rate,
  // datapath controls
  output logic            reclock_bypass,
  output logic            rate_mode_select,
  output logic      [1:0] manual_rate_select,
  output logic      [1:0] loop_bandwidth_control,
  output logic            primary_output_mute,
  output logic            secondary_output_mute,
  output logic            secondary_output_data_sel,
  output logic            deemphasis_enable,
  output logic      [3:0] eq_enable,
  output logic            host_mode
);

  // ==========================================================
  // input synchronisers
  logic [posc_pkg::SY_W-1:0] sync_meta_q;
  logic [posc_pkg::SY_W-1:0] sync_q;
  wire  [posc_pkg::SY_W-1:0] sync_raw;

  // all pins and analog status bits, packed for a common two-stage crossing
  assign sync_raw = {pll_locked_rate,
                     pll_rate_supported,
                     pll_locked,
                     rate_select_in,
                     sdo_eq1_in,
                     sdi_eq0_pin,
                     sck_eq2_pin,
                     cs_eq3_pin,
                     host_interface_select};

  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sync_meta_q <= posc_pkg::SY_RST;
      sync_q      <= posc_pkg::SY_RST;
    end else begin
      sync_meta_q <= sync_raw;
      sync_q      <= sync_meta_q;
    end
  end

  // ==========================================================
  // synchronised levels
  wire       hif_s       = sync_q[posc_pkg::SY_HOST_SEL];
  wire       cs_s        = sync_q[posc_pkg::SY_CS];
  wire       sck_s       = sync_q[posc_pkg::SY_SCK];
  wire       sdi_s       = sync_q[posc_pkg::SY_SDI];
  wire       sdo_in_s    = sync_q[posc_pkg::SY_SDO_IN];
  wire [1:0] rate_pin_s  = sync_q[posc_pkg::SY_RATE_LSB +: 2];
  wire       locked_s    = sync_q[posc_pkg::SY_LOCKED];
  wire       supported_s = sync_q[posc_pkg::SY_SUPP];
  wire [1:0] lock_rate_s = sync_q[posc_pkg::SY_LRATE +: 2];

  // ==========================================================
  // shared pin function
  wire       host_mode_d  = ~hif_s;
  wire       spi_active   = host_mode_d & ~cs_s;
  wire [3:0] eq_enable_d  = host_mode_d ? 4'h0 : {cs_s, sck_s, sdo_in_s, sdi_s};

  // ==========================================================
  // serial host slave
  logic [11:0] acc_addr;
  logic        wr_en;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic        sdo_bit;

  posc_spi_slave u_spi (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .spi_active (spi_active),
    .sck_lvl    (sck_s),
    .sdi_lvl    (sdi_s),
    .acc_addr   (acc_addr),
    .wr_en      (wr_en),
    .wr_data    (wr_data),
    .rd_data    (rd_data),
    .sdo_bit    (sdo_bit)
  );

  // ==========================================================
  // pin override register
  logic [15:0] ov_q;
  wire         ov_hit   = (acc_addr == posc_pkg::ADDR_PIN_OVERRIDE);
  wire         st_hit   = (acc_addr == posc_pkg::ADDR_STATUS);
  wire         ov_write = wr_en & ov_hit;

  // bits are stored whatever the enable state; reserved bits stay zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ov_q <= posc_pkg::PIN_OVERRIDE_RST;
    end else if (ov_write) begin
      ov_q <= wr_data & posc_pkg::PIN_OVERRIDE_MASK;
    end
  end

  // ==========================================================
  // override fields
  wire       ov_en       = ov_q[posc_pkg::OV_ENABLE_BIT];
  wire       ov_bypass   = ov_q[posc_pkg::OV_BYPASS_BIT];
  wire       ov_autobyp  = ov_q[posc_pkg::OV_AUTOBYPASS_BIT];
  wire       ov_ratemode = ov_q[posc_pkg::OV_RATE_MODE_BIT];
  wire [1:0] ov_rate_sel = ov_q[posc_pkg::OV_RATE_SEL_LSB +: 2];
  wire [1:0] ov_loop_bw  = ov_q[posc_pkg::OV_LOOP_BW_LSB +: 2];
  wire       ov_mute_n   = ov_q[posc_pkg::OV_MUTE_N_BIT];
  wire       ov_sec_data = ov_q[posc_pkg::OV_SEC_DATA_BIT];
  wire       ov_deemph   = ov_q[posc_pkg::OV_DEEMPH_BIT];

  // ==========================================================
  // effective levels: override when enabled, else resistor or pin
  wire       eff_bypass   = ov_en ? ov_bypass   : posc_pkg::RES_BYPASS;
  wire       eff_autobyp  = ov_en ? ov_autobyp  : posc_pkg::RES_AUTOBYPASS;
  wire       eff_ratemode = ov_en ? ov_ratemode : posc_pkg::RES_RATE_MODE;
  wire [1:0] eff_loop_bw  = ov_en ? ov_loop_bw  : posc_pkg::RES_LOOP_BW;
  wire       eff_mute_n   = ov_en ? ov_mute_n   : posc_pkg::RES_MUTE_N;
  wire       eff_sec_data = ov_en ? ov_sec_data : posc_pkg::RES_SEC_DATA;
  wire       eff_deemph   = ov_en ? ov_deemph   : posc_pkg::RES_DEEMPH;
  // manual rate comes from the pins, which define it, unless overridden
  wire [1:0] eff_man_rate = ov_en ? ov_rate_sel : rate_pin_s;

  // ==========================================================
  // datapath decisions
  wire       pll_ok       = locked_s & supported_s;
  wire       bypass_d     = eff_bypass | (eff_autobyp & ~pll_ok);
  wire       rate_oe_d    = eff_ratemode;
  wire [1:0] rate_out_d   = eff_ratemode ? lock_rate_s : 2'h0;
  wire [1:0] man_rate_d   = eff_ratemode ? 2'h0 : eff_man_rate;
  wire       prim_mute_d  = ~eff_mute_n;
  wire       sec_mute_d   = ~eff_mute_n & eff_sec_data;
  wire       sdo_oe_d     = spi_active;

  // ==========================================================
  // output flops
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reclock_bypass            <= posc_pkg::RES_BYPASS;
      rate_mode_select          <= posc_pkg::RES_RATE_MODE;
      manual_rate_select        <= 2'h0;
      rate_select_out           <= 2'h0;
      rate_select_oe            <= 1'b0;
      loop_bandwidth_control    <= posc_pkg::RES_LOOP_BW;
      primary_output_mute       <= ~posc_pkg::RES_MUTE_N;
      secondary_output_mute     <= 1'b0;
      secondary_output_data_sel <= posc_pkg::RES_SEC_DATA;
      deemphasis_enable         <= posc_pkg::RES_DEEMPH;
    end else begin
      reclock_bypass            <= bypass_d;
      rate_mode_select          <= eff_ratemode;
      manual_rate_select        <= man_rate_d;
      rate_select_out           <= rate_out_d;
      rate_select_oe            <= rate_oe_d;
      loop_bandwidth_control    <= eff_loop_bw;
      primary_output_mute       <= prim_mute_d;
      secondary_output_mute     <= sec_mute_d;
      secondary_output_data_sel <= eff_sec_data;
      deemphasis_enable         <= eff_deemph;
    end
  end

  // shared pin function and serial data out
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      host_mode   <= 1'b0;
      eq_enable   <= 4'h0;
      sdo_eq1_out <= 1'b0;
      sdo_eq1_oe  <= 1'b0;
    end else begin
      host_mode   <= host_mode_d;
      eq_enable   <= eq_enable_d;
      sdo_eq1_out <= sdo_bit & sdo_oe_d;
      sdo_eq1_oe  <= sdo_oe_d;
    end
  end

  // ==========================================================
  // status word
  logic [15:0] status_word;

  // live state of the block for the host
  always_comb begin
    status_word                                   = 16'h0000;
    status_word[posc_pkg::ST_OV_ACTIVE_BIT]       = ov_en;
    status_word[posc_pkg::ST_BYPASS_BIT]          = bypass_d;
    status_word[posc_pkg::ST_LOCKED_BIT]          = locked_s;
    status_word[posc_pkg::ST_SUPPORTED_BIT]       = supported_s;
    status_word[posc_pkg::ST_LOCK_RATE_LSB +: 2]  = lock_rate_s;
    status_word[posc_pkg::ST_HOST_MODE_BIT]       = host_mode_d;
    status_word[posc_pkg::ST_RATE_PIN_LSB +: 2]   = rate_pin_s;
  end

  // ==========================================================
  // read decode, unmapped addresses answer zero
  always_comb begin
    if (ov_hit) begin
      rd_data = ov_q;
    end else if (st_hit) begin
      rd_data = status_word;
    end else begin
      rd_data = 16'h0000;
    end
  end

endmodule : posc_top

// ---- common/posc_pkg.sv ----
// package: constants, field layout and types of the pin override and start-up block
package posc_pkg;

  // ==========================================================
  // register map
  localparam int unsigned       REG_W             = 16;
  localparam int unsigned       ADDR_W            = 12;
  localparam logic [11:0]       ADDR_PIN_OVERRIDE = 12'h00c;
  localparam logic [11:0]       ADDR_STATUS       = 12'h00d;
  localparam logic [15:0]       PIN_OVERRIDE_RST  = 16'h0000;
  localparam logic [15:0]       PIN_OVERRIDE_MASK = 16'h83ff;

  // ==========================================================
  // pin override register fields
  localparam int unsigned OV_BYPASS_BIT     = 0;
  localparam int unsigned OV_AUTOBYPASS_BIT = 1;
  localparam int unsigned OV_RATE_MODE_BIT  = 2;
  localparam int unsigned OV_RATE_SEL_LSB   = 3;
  localparam int unsigned OV_LOOP_BW_LSB    = 5;
  localparam int unsigned OV_MUTE_N_BIT     = 7;
  localparam int unsigned OV_SEC_DATA_BIT   = 8;
  localparam int unsigned OV_DEEMPH_BIT     = 9;
  localparam int unsigned OV_ENABLE_BIT     = 15;

  // ==========================================================
  // status register fields
  localparam int unsigned ST_OV_ACTIVE_BIT  = 0;
  localparam int unsigned ST_BYPASS_BIT     = 1;
  localparam int unsigned ST_LOCKED_BIT     = 2;
  localparam int unsigned ST_SUPPORTED_BIT  = 3;
  localparam int unsigned ST_LOCK_RATE_LSB  = 4;
  localparam int unsigned ST_HOST_MODE_BIT  = 6;
  localparam int unsigned ST_RATE_PIN_LSB   = 7;

  // ==========================================================
  // loop bandwidth levels
  typedef enum logic [1:0] {
    POSC_LOOP_BW_GROUND = 2'b00,
    POSC_LOOP_BW_FLOAT  = 2'b01,
    POSC_LOOP_BW_VCC    = 2'b10
  } posc_loop_bw_t;

  // ==========================================================
  // levels set by the internal pull resistors
  localparam logic          RES_BYPASS     = 1'b0;
  localparam logic          RES_AUTOBYPASS = 1'b0;
  localparam logic          RES_RATE_MODE  = 1'b1;
  localparam posc_loop_bw_t RES_LOOP_BW    = POSC_LOOP_BW_FLOAT;
  localparam logic          RES_MUTE_N     = 1'b1;
  localparam logic          RES_SEC_DATA   = 1'b0;
  localparam logic          RES_DEEMPH     = 1'b0;

  // ==========================================================
  // serial host frame
  localparam logic [5:0]  SPI_CMD_BITS   = 6'h10;
  localparam logic [5:0]  SPI_FRAME_BITS = 6'h20;
  localparam int unsigned SPI_READ_BIT   = 15;

  typedef enum logic [2:0] {
    POSC_SPI_IDLE = 3'b000,
    POSC_SPI_CMD  = 3'b001,
    POSC_SPI_LOAD = 3'b010,
    POSC_SPI_DATA = 3'b011,
    POSC_SPI_DONE = 3'b100
  } posc_spi_state_t;

  // ==========================================================
  // positions in the input synchroniser vector
  localparam int unsigned SY_HOST_SEL = 0;
  localparam int unsigned SY_CS       = 1;
  localparam int unsigned SY_SCK      = 2;
  localparam int unsigned SY_SDI      = 3;
  localparam int unsigned SY_SDO_IN   = 4;
  localparam int unsigned SY_RATE_LSB = 5;
  localparam int unsigned SY_LOCKED   = 7;
  localparam int unsigned SY_SUPP     = 8;
  localparam int unsigned SY_LRATE    = 9;
  localparam int unsigned SY_W        = 11;
  localparam logic [10:0] SY_RST      = 11'h003;

endpackage : posc_pkg

// ---- rtl/posc_spi_slave.sv ----
// module: serial host port slave, frame decode and register access strobes
`timescale 1ns/1ns
module posc_spi_slave (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // synchronised serial levels
  input  wire logic        spi_active,
  input  wire logic        sck_lvl,
  input  wire logic        sdi_lvl,
  // register access
  output logic [11:0]      acc_addr,
  output logic             wr_en,
  output logic [15:0]      wr_data,
  input  wire logic [15:0] rd_data,
  // serial data out
  output logic             sdo_bit
);

  // ==========================================================
  // state and edge detection
  posc_pkg::posc_spi_state_t state_q;
  posc_pkg::posc_spi_state_t state_d;
  logic        sck_prev_q;
  logic [5:0]  bit_cnt_q;
  logic [15:0] shift_q;
  logic [15:0] out_q;
  logic [11:0] addr_q;
  logic        is_read_q;
  logic        sdo_q;
  logic        wr_en_q;
  logic [15:0] wr_data_q;

  wire         sck_rise  = sck_lvl & ~sck_prev_q;
  wire         sck_fall  = ~sck_lvl & sck_prev_q;
  wire  [15:0] shift_nxt = {shift_q[14:0], sdi_lvl};
  wire  [5:0]  cnt_nxt   = 6'(bit_cnt_q + 6'h01);
  wire         last_cmd  = sck_rise & (cnt_nxt == posc_pkg::SPI_CMD_BITS);
  wire         last_data = sck_rise & (cnt_nxt == posc_pkg::SPI_FRAME_BITS);

  // frame sequencing, abandoned whenever chip select rises
  always_comb begin
    state_d = state_q;
    case (state_q)
      posc_pkg::POSC_SPI_IDLE: if (spi_active) state_d = posc_pkg::POSC_SPI_CMD;
      posc_pkg::POSC_SPI_CMD:  if (last_cmd) state_d = posc_pkg::POSC_SPI_LOAD;
      posc_pkg::POSC_SPI_LOAD: state_d = posc_pkg::POSC_SPI_DATA;
      posc_pkg::POSC_SPI_DATA: if (last_data) state_d = posc_pkg::POSC_SPI_DONE;
      default:                 state_d = state_q;
    endcase
    if (!spi_active) state_d = posc_pkg::POSC_SPI_IDLE;
  end

  // state, counter and input shifter
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q    <= posc_pkg::POSC_SPI_IDLE;
      sck_prev_q <= 1'b0;
      bit_cnt_q  <= 6'h00;
      shift_q    <= 16'h0000;
    end else begin
      state_q    <= state_d;
      sck_prev_q <= sck_lvl;
      if (state_q == posc_pkg::POSC_SPI_IDLE) begin
        bit_cnt_q <= 6'h00;
      end else if (sck_rise) begin
        bit_cnt_q <= cnt_nxt;
        shift_q   <= shift_nxt;
      end
    end
  end

  // command capture and read data load
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      addr_q    <= 12'h000;
      is_read_q <= 1'b0;
      out_q     <= 16'h0000;
      sdo_q     <= 1'b0;
    end else begin
      if (state_q == posc_pkg::POSC_SPI_CMD && last_cmd) begin
        addr_q    <= shift_nxt[11:0];
        is_read_q <= shift_nxt[posc_pkg::SPI_READ_BIT];
      end
      if (state_q == posc_pkg::POSC_SPI_LOAD) begin
        out_q <= rd_data;
      end else if (state_q == posc_pkg::POSC_SPI_DATA && sck_fall) begin
        sdo_q <= out_q[15];
        out_q <= {out_q[14:0], 1'b0};
      end else if (state_q == posc_pkg::POSC_SPI_IDLE) begin
        sdo_q <= 1'b0;
      end
    end
  end

  // one-cycle write strobe at the last data bit of a write frame
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_en_q   <= 1'b0;
      wr_data_q <= 16'h0000;
    end else begin
      wr_en_q <= (state_q == posc_pkg::POSC_SPI_DATA) & last_data & ~is_read_q;
      if ((state_q == posc_pkg::POSC_SPI_DATA) & last_data) wr_data_q <= shift_nxt;
    end
  end

  assign acc_addr = addr_q;
  assign wr_en    = wr_en_q;
  assign wr_data  = wr_data_q;
  assign sdo_bit  = sdo_q;

endmodule : posc_spi_slave

// ---- dv/posc_host_model.sv ----
// partner model: serial host controller on the shared host pins
`timescale 1ns/1ns
module posc_host_model #(
  parameter int HALF_NS = 80
) (
  // serial host pins
  output logic     cs_n,
  output logic     sck,
  output logic     sdi,
  input wire logic sdo
);
  // ==========================================================
  // idle levels, link clock stands low outside frames
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    sdi  = 1'b0;
  end

  // one frame: command word then data word, msb first, mode 0
  task automatic frame(input logic [31:0] w, output logic [15:0] rd);
    cs_n = 1'b0;
    #HALF_NS;
    for (int i = 31; i >= 0; i--) begin
      sdi = w[i];
      #HALF_NS sck = 1'b1;
      if (i < 16) rd[i] = sdo;
      #HALF_NS sck = 1'b0;
    end
    #HALF_NS cs_n = 1'b1;
    sdi = ~sdi; // released line keeps no stale level
    #(2 * HALF_NS);
  endtask : frame
endmodule : posc_host_model

// ---- dv/posc_top_chk.sv ----
// checker: concurrent properties on the pin override block ports
`timescale 1ns/1ns
module posc_top_chk (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // observed ports
  input wire logic       host_interface_select,
  input wire logic       sdo_eq1_out,
  input wire logic       sdo_eq1_oe,
  input wire logic [1:0] rate_select_out,
  input wire logic       rate_select_oe,
  input wire logic       rate_mode_select,
  input wire logic [1:0] manual_rate_select,
  input wire logic [1:0] loop_bandwidth_control,
  input wire logic       primary_output_mute,
  input wire logic       secondary_output_mute,
  input wire logic       secondary_output_data_sel,
  input wire logic       reclock_bypass,
  input wire logic [3:0] eq_enable,
  input wire logic       host_mode
);
  // ==========================================================
  // properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_reset_defaults: assert property ($rose(rst_n) |-> rate_mode_select && !reclock_bypass &&
    loop_bandwidth_control == 2'h1 && !primary_output_mute && eq_enable == 4'h0)
    else $error("start-up levels wrong after reset");
  a_sec_mute_rel: assert property (secondary_output_mute == (primary_output_mute && secondary_output_data_sel))
    else $error("secondary mute does not follow mute and data select");
  a_rate_oe_auto: assert property ($past(rst_n) |-> rate_select_oe == rate_mode_select)
    else $error("rate pins direction differs from rate mode");
  a_rate_out_idle: assert property (!rate_select_oe |-> rate_select_out == 2'h0)
    else $error("rate pins driven while not reporting");
  a_manual_auto_zero: assert property (rate_mode_select |-> manual_rate_select == 2'h0)
    else $error("manual rate set in automatic mode");
  a_loop_bw_legal: assert property (loop_bandwidth_control != 2'h3)
    else $error("illegal loop bandwidth level");
  a_host_follow: assert property ($stable(host_interface_select)[*5] |-> host_mode == !host_interface_select)
    else $error("host mode does not follow interface select");
  a_eq_host_zero: assert property (host_mode |-> eq_enable == 4'h0)
    else $error("equaliser enables active in host mode");
  a_sdo_oe_host: assert property (sdo_eq1_oe |-> host_mode)
    else $error("data out driven outside host mode");
  a_sdo_quiet: assert property (!sdo_eq1_oe |-> !sdo_eq1_out)
    else $error("data out level while not driving");

  // main scenarios reached
  cover property (sdo_eq1_oe);
  cover property (reclock_bypass);
  cover property (secondary_output_mute);
  cover property ($fell(host_mode));
endmodule : posc_top_chk

bind posc_top posc_top_chk i_posc_top_chk (
  .core_clk, .rst_n, .host_interface_select, .sdo_eq1_out, .sdo_eq1_oe, .rate_select_out, .rate_select_oe,
  .rate_mode_select, .manual_rate_select, .loop_bandwidth_control, .primary_output_mute, .secondary_output_mute,
  .secondary_output_data_sel, .reclock_bypass, .eq_enable, .host_mode
);

// ---- dv/posc_top_tb_top.sv ----
// testbench: pin override block driven through its serial host port and shared pins
`timescale 1ns/1ns
module posc_top_tb_top;
  // ==========================================================
  // pins, controls and counters
  logic       core_clk, rst_n, host_interface_select, pll_locked, pll_rate_supported, h_cs_n, h_sck, h_sdi;
  logic [1:0] rate_select_in, pll_locked_rate, rate_select_out, manual_rate_select, loop_bandwidth_control;
  logic [3:0] eq_pat, eq_enable;
  logic       sdo_eq1_out, sdo_eq1_oe, rate_select_oe, reclock_bypass, rate_mode_select, host_mode;
  logic       primary_output_mute, secondary_output_mute, secondary_output_data_sel, deemphasis_enable;
  wire        cs_eq3_pin, sck_eq2_pin, sdi_eq0_pin, sdo_eq1_in;
  wire [12:0] obs;
  int         miscompares, samples_checked, cyc;
  localparam logic [11:0] OVR = posc_pkg::ADDR_PIN_OVERRIDE;

  // shared pins: host controller in host mode, equaliser pattern otherwise
  assign cs_eq3_pin  = host_interface_select ? eq_pat[3] : h_cs_n;
  assign sck_eq2_pin = host_interface_select ? eq_pat[2] : h_sck;
  assign sdi_eq0_pin = host_interface_select ? eq_pat[0] : h_sdi;
  assign sdo_eq1_in  = sdo_eq1_oe ? sdo_eq1_out : (host_interface_select ? eq_pat[1] : !sdo_eq1_out);
  assign obs = {reclock_bypass, rate_mode_select, manual_rate_select, loop_bandwidth_control, primary_output_mute,
                secondary_output_mute, secondary_output_data_sel, deemphasis_enable, rate_select_oe, rate_select_out};

  posc_top i_posc_top (
    .core_clk, .rst_n, .host_interface_select, .cs_eq3_pin, .sck_eq2_pin, .sdi_eq0_pin, .sdo_eq1_in,
    .sdo_eq1_out, .sdo_eq1_oe, .rate_select_in, .rate_select_out, .rate_select_oe, .pll_locked,
    .pll_rate_supported, .pll_locked_rate, .reclock_bypass, .rate_mode_select, .manual_rate_select,
    .loop_bandwidth_control, .primary_output_mute, .secondary_output_mute, .secondary_output_data_sel,
    .deemphasis_enable, .eq_enable, .host_mode
  );
  posc_host_model i_posc_host_model (.cs_n(h_cs_n), .sck(h_sck), .sdi(h_sdi), .sdo(sdo_eq1_in));

  // ==========================================================
  // clock and hang guard
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end

  // ==========================================================
  // helpers
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic reg_wr(input logic [11:0] a, input logic [15:0] d);
    logic [15:0] rd;
    i_posc_host_model.frame({4'h0, a, d}, rd);
    settle(8);
  endtask : reg_wr
  task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_posc_host_model.frame({4'h8, a, 16'h0000}, d);
    chk("register read", exp, d);
    settle(1);
  endtask : rd_chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // ==========================================================
  // scenarios
  task automatic t_defaults();
    chk("host mode", 16'h0001, {15'h0, host_mode});
    chk("outputs", 16'h0886, {3'h0, obs});
    rd_chk(OVR, 16'h0000);
    rd_chk(posc_pkg::ADDR_STATUS, 16'h00ec);
  endtask : t_defaults
  task automatic t_stored();
    reg_wr(OVR, 16'h0349);
    chk("outputs", 16'h0886, {3'h0, obs});
    rd_chk(OVR, 16'h0349);
    reg_wr(OVR, 16'h8349);
    chk("outputs", 16'h1378, {3'h0, obs});
  endtask : t_stored
  task automatic t_ovr_defaults();
    reg_wr(OVR, 16'h8000);
    chk("outputs", 16'h0040, {3'h0, obs});
    reg_wr(OVR, 16'h0000);
    chk("outputs", 16'h0886, {3'h0, obs});
  endtask : t_ovr_defaults
  task automatic t_autobypass();
    reg_wr(OVR, 16'h8002);
    chk("outputs", 16'h0040, {3'h0, obs});
    pll_rate_supported = 1'b0;
    settle(6);
    chk("outputs", 16'h1040, {3'h0, obs});
    pll_rate_supported = 1'b1;
    pll_locked = 1'b0;
    settle(6);
    chk("outputs", 16'h1040, {3'h0, obs});
    pll_locked = 1'b1;
    pll_locked_rate = 2'h1;
    reg_wr(OVR, 16'h0000);
    chk("outputs", 16'h0885, {3'h0, obs});
  endtask : t_autobypass
  task automatic t_refused();
    reg_wr(12'h005, 16'hffff);
    reg_wr(OVR, 16'hfc00);
    rd_chk(12'h005, 16'h0000);
    rd_chk(OVR, 16'h8000);
    rd_chk(posc_pkg::ADDR_STATUS, 16'h00dd);
    reg_wr(OVR, 16'h0000);
  endtask : t_refused
  task automatic t_reset();
    reg_wr(OVR, 16'h8349);
    chk("outputs", 16'h1378, {3'h0, obs});
    rst_n = 1'b0;
    settle(4);
    rst_n = 1'b1;
    settle(6);
    chk("outputs", 16'h0885, {3'h0, obs});
    chk("host mode", 16'h0001, {15'h0, host_mode});
    rd_chk(OVR, 16'h0000);
  endtask : t_reset
  task automatic t_nonhost();
    host_interface_select = 1'b1;
    eq_pat = 4'ha;
    settle(6);
    chk("equaliser enables", 16'h000a, {12'h0, eq_enable});
    chk("host mode", 16'h0000, {15'h0, host_mode});
    host_interface_select = 1'b0;
    settle(6);
  endtask : t_nonhost

  // main sequence
  initial begin
    rst_n = 1'b0;
    host_interface_select = 1'b0;
    eq_pat = 4'h0;
    rate_select_in = 2'h1;
    pll_locked = 1'b1;
    pll_rate_supported = 1'b1;
    pll_locked_rate = 2'h2;
    repeat (20) @(posedge core_clk);
    #1 rst_n = 1'b1;
    settle(6);
    t_defaults();
    t_stored();
    t_ovr_defaults();
    t_autobypass();
    t_refused();
    t_reset();
    t_nonhost();
    final_report();
  end
endmodule : posc_top_tb_top
